/* File: core/evf_defines.vh */
// Constants for the event flag registers: offsets, bit positions,
// reset values, edge selections and start-up timing.
// Assumes it is included once per design file by its bare name.
`ifndef EVF_DEFINES_VH
`define EVF_DEFINES_VH

// Register offsets on the register port.
`define EVF_ADDR_CHG        8'h09
`define EVF_ADDR_LINK       8'h0A
`define EVF_ADDR_XFER       8'h0B
`define EVF_ADDR_CMD_STATUS 8'h05

// Reset values.
`define EVF_FLAGS_RESET     8'h00
`define EVF_CODE_RESET      8'h00
`define EVF_READ_UNMAPPED   8'h00

// Charger event flag bits.
`define EVF_CHG_TEMP        7
`define EVF_CHG_REVERSE     6
`define EVF_CHG_VREG        5
`define EVF_CHG_STEP        4
`define EVF_CHG_DROPOUT     3
`define EVF_CHG_SYS_DROPOUT 2
`define EVF_CHG_LINE_GOOD   1
`define EVF_CHG_SYS_REVERSE 0

// Link event flag bits.
`define EVF_LNK_CONNECTED   7
`define EVF_LNK_WAITING     6
`define EVF_LNK_IDLE        5
`define EVF_LNK_SHORT_RISE  4
`define EVF_LNK_SHORT_FALL  3
`define EVF_LNK_NEW_DATA    2
`define EVF_LNK_CMD_DONE    1
`define EVF_LNK_CMD_ERROR   0

// Transfer and moisture event flag bits.
`define EVF_XFM_LONG        7
`define EVF_XFM_UNDERVOLT   6
`define EVF_XFM_MOIST_DONE  5
`define EVF_XFM_MOIST_DET   4
`define EVF_XFM_MOIST_VALID 3
`define EVF_XFM_RES_ABORT   2
`define EVF_XFM_RES_OPEN    1
`define EVF_XFM_RES_GROUND  0

// Edge selections per register: rising, falling, one-cycle event.
`define EVF_CHG_RISE_MASK   8'hFF
`define EVF_CHG_FALL_MASK   8'hFF
`define EVF_CHG_PULSE_MASK  8'h00
`define EVF_LNK_RISE_MASK   8'hF0
`define EVF_LNK_FALL_MASK   8'hE8
`define EVF_LNK_PULSE_MASK  8'h07
`define EVF_XFM_RISE_MASK   8'hD0
`define EVF_XFM_FALL_MASK   8'hD0
`define EVF_XFM_PULSE_MASK  8'h2F

// Cycles after reset release before change detection is armed.
`define EVF_ARM_CYCLES      2'h3
`define EVF_ARM_ZERO        2'h0
`define EVF_ARM_STEP        2'h1

`endif

/* File: core/evf_sync.v */
// Two-flop synchroniser for a bus of independent status levels.
// Assumes each bit is a slow level from outside the clock domain.
`include "evf_defines.vh"

module evf_sync #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // The first stage is read only by the second stage.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // evf_sync

/* File: core/evf_edge_flags.v */
// One register of sticky event flags, each bit set by a chosen edge
// of a level or by a one-cycle event, and cleared by writing a one.
// Assumes levels are already synchronised and events are on this clock.
`include "evf_defines.vh"

module evf_edge_flags #(
    parameter       W          = 8,
    parameter [W-1:0] RISE_MASK  = {W{1'b1}},
    parameter [W-1:0] FALL_MASK  = {W{1'b1}},
    parameter [W-1:0] PULSE_MASK = {W{1'b0}}
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         arm_i,
    input  wire [W-1:0] level_i,
    input  wire [W-1:0] pulse_i,
    input  wire [W-1:0] clear_i,
    output wire [W-1:0] flags_o
);

    reg  [W-1:0] prev_q;
    reg  [W-1:0] flag_q;
    wire [W-1:0] set_w;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign set_w[i] = (RISE_MASK[i] & arm_i & level_i[i] & ~prev_q[i])
                            | (FALL_MASK[i] & arm_i & ~level_i[i] & prev_q[i])
                            | (PULSE_MASK[i] & pulse_i[i]);
            // A set in the clearing cycle wins, so no event is lost.
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    prev_q[i] <= 1'b0;
                    flag_q[i] <= 1'b0;
                end else begin
                    prev_q[i] <= level_i[i];
                    flag_q[i] <= (flag_q[i] & ~clear_i[i]) | set_w[i];
                end
            end
        end
    endgenerate

    assign flags_o = flag_q;

endmodule // evf_edge_flags

/* File: core/evf_event_flags.v */
// Top of the event flag block: three sticky flag registers fed by
// charger, regulator, link, transfer and moisture status sources.
// Assumes level statuses come from outside the clock domain and event
// strobes are one-cycle pulses from logic on CLK_I.
//
// Summary of operation
// (R1) Temperature regulation change sets charger bit 7.
// (R2) Charger reverse change sets charger bit 6.
// (R3) Battery voltage regulation change sets bit 5.
// (R4) Step charge change sets charger bit 4.
// (R5) Charger dropout change sets charger bit 3.
// (R6) Regulator dropout change sets charger bit 2.
// (R7) Line voltage good change sets bit 1.
// (R8) Regulator reverse change sets charger bit 0.
// (R9) Link connected change sets link bit 7.
// (R10) Link waiting change sets link bit 6.
// (R11) Link idle change sets link bit 5.
// (R12) Short transfer rising edge sets bit 4.
// (R13) Short transfer falling edge sets bit 3.
// (R14) New data stored sets link bit 2.
// (R15) Command completion sets link bit 1.
// (R16) Command error sets link bit 0.
// (R17) Long transfer change sets bit 7.
// (R18) Undervoltage status change sets bit 6.
// (R19) Moisture measurement finished sets bit 5.
// (R20) Moisture detected change sets bit 4.
// (R21) Valid moisture result sets bit 3.
// (R22) Abort, open, ground results set bits 2..0.
// (R23) Command code valid after done or error.
// (R24) Flags stay set until cleared; reset zeroes.
`include "evf_defines.vh"

module evf_event_flags #(
    parameter W = 8
) (
    // Clock and reset.
    input  wire         CLK_I,
    input  wire         RST_N_I,

    // Register port.
    input  wire [7:0]   REG_ADDR_I,
    input  wire         REG_WR_I,
    input  wire [W-1:0] REG_WDATA_I,
    input  wire         REG_RD_I,
    output reg  [W-1:0] REG_RDATA_O,
    output reg          REG_RDATA_VALID_O,

    // Charger and regulator status levels.
    input  wire         TEMP_REGULATION_STATE_I,
    input  wire         CHARGER_REVERSE_STATE_I,
    input  wire         BATT_VOLTAGE_REGULATION_STATE_I,
    input  wire         STEP_CHARGE_STATE_I,
    input  wire         CHARGER_DROPOUT_STATE_I,
    input  wire         SYS_REGULATOR_DROPOUT_STATE_I,
    input  wire         LINE_VOLTAGE_GOOD_I,
    input  wire         SYS_REVERSE_STATE_I,

    // Link status levels.
    input  wire         LINK_CONNECTED_STATE_I,
    input  wire         LINK_WAITING_STATE_I,
    input  wire         LINK_IDLE_STATE_I,
    input  wire         SHORT_TRANSFER_STATE_I,
    input  wire         LONG_TRANSFER_STATE_I,

    // Battery and moisture status levels.
    input  wire         BATT_ABOVE_UNDERVOLTAGE_I,
    input  wire         LINE_MOISTURE_STATE_I,

    // Link event strobes.
    input  wire         NEW_DATA_STORED_I,
    input  wire         CMD_DONE_I,
    input  wire         CMD_ERROR_I,
    input  wire [W-1:0] CMD_STATUS_CODE_I,

    // Moisture measurement event strobes.
    input  wire         MOIST_DONE_I,
    input  wire         MOIST_VALID_I,
    input  wire         RES_ABORT_I,
    input  wire         RES_OPEN_I,
    input  wire         RES_GROUND_I,

    // Flag and code outputs towards mask logic.
    output wire [W-1:0] CHARGER_EVENT_FLAGS_O,
    output wire [W-1:0] LINK_EVENT_FLAGS_O,
    output wire [W-1:0] TRANSFER_MOISTURE_EVENT_FLAGS_O,
    output reg  [W-1:0] CMD_STATUS_O
);

    ////////////////////////////////////////////////////////////////////
    // Declarations.

    wire [W-1:0] chg_raw;
    wire [W-1:0] chg_lvl;
    wire [W-1:0] lnk_raw;
    wire [W-1:0] lnk_lvl;
    wire [W-1:0] lnk_evt;
    wire [W-1:0] xfm_raw;
    wire [W-1:0] xfm_lvl;
    wire [W-1:0] xfm_evt;
    wire [W-1:0] chg_flags;
    wire [W-1:0] lnk_flags;
    wire [W-1:0] xfm_flags;
    wire [W-1:0] chg_clr;
    wire [W-1:0] lnk_clr;
    wire [W-1:0] xfm_clr;
    wire         wr_chg;
    wire         wr_lnk;
    wire         wr_xfm;
    wire         armed;
    reg  [1:0]   arm_cnt_q;
    reg  [1:0]   arm_cnt_d;
    reg  [W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////////
    // Charger and regulator sources.

    // (R1) Temperature regulation source.
    assign chg_raw[`EVF_CHG_TEMP] = TEMP_REGULATION_STATE_I;
    // (R2) Charger reverse source.
    assign chg_raw[`EVF_CHG_REVERSE] = CHARGER_REVERSE_STATE_I;
    // (R3) Voltage regulation source.
    assign chg_raw[`EVF_CHG_VREG] = BATT_VOLTAGE_REGULATION_STATE_I;
    // (R4) Step charge source.
    assign chg_raw[`EVF_CHG_STEP] = STEP_CHARGE_STATE_I;
    // (R5) Charger dropout source.
    assign chg_raw[`EVF_CHG_DROPOUT] = CHARGER_DROPOUT_STATE_I;
    // (R6) Regulator dropout source.
    assign chg_raw[`EVF_CHG_SYS_DROPOUT] = SYS_REGULATOR_DROPOUT_STATE_I;
    // (R7) Line voltage source.
    assign chg_raw[`EVF_CHG_LINE_GOOD] = LINE_VOLTAGE_GOOD_I;
    // (R8) Regulator reverse source.
    assign chg_raw[`EVF_CHG_SYS_REVERSE] = SYS_REVERSE_STATE_I;

    ////////////////////////////////////////////////////////////////////
    // Link sources.

    // (R9) Connected source.
    assign lnk_raw[`EVF_LNK_CONNECTED] = LINK_CONNECTED_STATE_I;
    // (R10) Waiting source.
    assign lnk_raw[`EVF_LNK_WAITING] = LINK_WAITING_STATE_I;
    // (R11) Idle source.
    assign lnk_raw[`EVF_LNK_IDLE] = LINK_IDLE_STATE_I;
    // (R12) Short transfer, rising.
    assign lnk_raw[`EVF_LNK_SHORT_RISE] = SHORT_TRANSFER_STATE_I;
    // (R13) Short transfer, falling.
    assign lnk_raw[`EVF_LNK_SHORT_FALL] = SHORT_TRANSFER_STATE_I;
    assign lnk_raw[`EVF_LNK_NEW_DATA] = 1'b0;
    assign lnk_raw[`EVF_LNK_CMD_DONE] = 1'b0;
    assign lnk_raw[`EVF_LNK_CMD_ERROR] = 1'b0;

    assign lnk_evt[`EVF_LNK_CONNECTED] = 1'b0;
    assign lnk_evt[`EVF_LNK_WAITING] = 1'b0;
    assign lnk_evt[`EVF_LNK_IDLE] = 1'b0;
    assign lnk_evt[`EVF_LNK_SHORT_RISE] = 1'b0;
    assign lnk_evt[`EVF_LNK_SHORT_FALL] = 1'b0;
    // (R14) New data strobe.
    assign lnk_evt[`EVF_LNK_NEW_DATA] = NEW_DATA_STORED_I;
    // (R15) Command done strobe.
    assign lnk_evt[`EVF_LNK_CMD_DONE] = CMD_DONE_I;
    // (R16) Command error strobe.
    assign lnk_evt[`EVF_LNK_CMD_ERROR] = CMD_ERROR_I;

    ////////////////////////////////////////////////////////////////////
    // Transfer and moisture sources.

    // (R17) Long transfer source.
    assign xfm_raw[`EVF_XFM_LONG] = LONG_TRANSFER_STATE_I;
    // (R18) Undervoltage source.
    assign xfm_raw[`EVF_XFM_UNDERVOLT] = BATT_ABOVE_UNDERVOLTAGE_I;
    assign xfm_raw[`EVF_XFM_MOIST_DONE] = 1'b0;
    // (R20) Moisture detected source.
    assign xfm_raw[`EVF_XFM_MOIST_DET] = LINE_MOISTURE_STATE_I;
    assign xfm_raw[`EVF_XFM_MOIST_VALID] = 1'b0;
    assign xfm_raw[`EVF_XFM_RES_ABORT] = 1'b0;
    assign xfm_raw[`EVF_XFM_RES_OPEN] = 1'b0;
    assign xfm_raw[`EVF_XFM_RES_GROUND] = 1'b0;

    assign xfm_evt[`EVF_XFM_LONG] = 1'b0;
    assign xfm_evt[`EVF_XFM_UNDERVOLT] = 1'b0;
    // (R19) Measurement done strobe.
    assign xfm_evt[`EVF_XFM_MOIST_DONE] = MOIST_DONE_I;
    assign xfm_evt[`EVF_XFM_MOIST_DET] = 1'b0;
    // (R21) Valid result strobe.
    assign xfm_evt[`EVF_XFM_MOIST_VALID] = MOIST_VALID_I;
    // (R22) Resistive outcome strobes.
    assign xfm_evt[`EVF_XFM_RES_ABORT] = RES_ABORT_I;
    assign xfm_evt[`EVF_XFM_RES_OPEN] = RES_OPEN_I;
    assign xfm_evt[`EVF_XFM_RES_GROUND] = RES_GROUND_I;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers for the status levels.

    evf_sync #(
        .W (W)
    ) u_sync_chg (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .async_i (chg_raw),
        .sync_o  (chg_lvl)
    );

    evf_sync #(
        .W (W)
    ) u_sync_lnk (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .async_i (lnk_raw),
        .sync_o  (lnk_lvl)
    );

    evf_sync #(
        .W (W)
    ) u_sync_xfm (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .async_i (xfm_raw),
        .sync_o  (xfm_lvl)
    );

    ////////////////////////////////////////////////////////////////////
    // Start-up arming.

    // The synchronisers and edge history start at zero, so a status
    // that is already high at reset would look like a change. Edge
    // detection waits until the history holds real samples.
    always @* begin
        arm_cnt_d = arm_cnt_q;
        if (arm_cnt_q != `EVF_ARM_CYCLES) begin
            arm_cnt_d = arm_cnt_q + `EVF_ARM_STEP;
        end
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            arm_cnt_q <= `EVF_ARM_ZERO;
        end else begin
            arm_cnt_q <= arm_cnt_d;
        end
    end

    assign armed = (arm_cnt_q == `EVF_ARM_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // Write decode: a one written to a flag bit clears it.

    assign wr_chg = REG_WR_I && (REG_ADDR_I == `EVF_ADDR_CHG);
    assign wr_lnk = REG_WR_I && (REG_ADDR_I == `EVF_ADDR_LINK);
    assign wr_xfm = REG_WR_I && (REG_ADDR_I == `EVF_ADDR_XFER);

    // (R24) Software clear strobes.
    assign chg_clr = wr_chg ? REG_WDATA_I : {W{1'b0}};
    assign lnk_clr = wr_lnk ? REG_WDATA_I : {W{1'b0}};
    assign xfm_clr = wr_xfm ? REG_WDATA_I : {W{1'b0}};

    ////////////////////////////////////////////////////////////////////
    // Flag registers.

    // (R1) Any-edge charger flags.
    evf_edge_flags #(
        .W          (W),
        .RISE_MASK  (`EVF_CHG_RISE_MASK),
        .FALL_MASK  (`EVF_CHG_FALL_MASK),
        .PULSE_MASK (`EVF_CHG_PULSE_MASK)
    ) u_flags_chg (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .arm_i   (armed),
        .level_i (chg_lvl),
        .pulse_i ({W{1'b0}}),
        .clear_i (chg_clr),
        .flags_o (chg_flags)
    );

    // (R12) Edge-selected link flags.
    evf_edge_flags #(
        .W          (W),
        .RISE_MASK  (`EVF_LNK_RISE_MASK),
        .FALL_MASK  (`EVF_LNK_FALL_MASK),
        .PULSE_MASK (`EVF_LNK_PULSE_MASK)
    ) u_flags_lnk (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .arm_i   (armed),
        .level_i (lnk_lvl),
        .pulse_i (lnk_evt),
        .clear_i (lnk_clr),
        .flags_o (lnk_flags)
    );

    // (R17) Transfer and moisture flags.
    evf_edge_flags #(
        .W          (W),
        .RISE_MASK  (`EVF_XFM_RISE_MASK),
        .FALL_MASK  (`EVF_XFM_FALL_MASK),
        .PULSE_MASK (`EVF_XFM_PULSE_MASK)
    ) u_flags_xfm (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .arm_i   (armed),
        .level_i (xfm_lvl),
        .pulse_i (xfm_evt),
        .clear_i (xfm_clr),
        .flags_o (xfm_flags)
    );

    assign CHARGER_EVENT_FLAGS_O           = chg_flags;
    assign LINK_EVENT_FLAGS_O              = lnk_flags;
    assign TRANSFER_MOISTURE_EVENT_FLAGS_O = xfm_flags;

    ////////////////////////////////////////////////////////////////////
    // Command status code.

    // (R23) Latch code with done/error.
    // The code is captured in the same cycle as the flag is raised, so
    // software that waits for either flag never sees a stale value.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            CMD_STATUS_O <= `EVF_CODE_RESET;
        end else if (CMD_DONE_I || CMD_ERROR_I) begin
            CMD_STATUS_O <= CMD_STATUS_CODE_I;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path.

    always @* begin
        case (REG_ADDR_I)
            `EVF_ADDR_CHG: begin
                rdata_d = chg_flags;
            end
            `EVF_ADDR_LINK: begin
                rdata_d = lnk_flags;
            end
            `EVF_ADDR_XFER: begin
                rdata_d = xfm_flags;
            end
            `EVF_ADDR_CMD_STATUS: begin
                rdata_d = CMD_STATUS_O;
            end
            default: begin
                rdata_d = `EVF_READ_UNMAPPED;
            end
        endcase
    end

    // Read data is held until the next read; reads have no side effect.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O       <= `EVF_READ_UNMAPPED;
            REG_RDATA_VALID_O <= 1'b0;
        end else begin
            REG_RDATA_VALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_d;
            end
        end
    end

endmodule // evf_event_flags

/* File: verif/evf_event_flags_props.sv */
// Concurrent checks for the event flag block, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`include "evf_defines.vh"

module evf_event_flags_props #(
    parameter W = 8
) (
    // Clock, reset and register port.
    input logic         CLK_I,
    input logic         RST_N_I,
    input logic [7:0]   REG_ADDR_I,
    input logic         REG_WR_I,
    input logic [W-1:0] REG_WDATA_I,
    // Sources.
    input logic         TEMP_REGULATION_STATE_I,
    input logic         SHORT_TRANSFER_STATE_I,
    input logic         CMD_DONE_I,
    input logic         CMD_ERROR_I,
    input logic [W-1:0] CMD_STATUS_CODE_I,
    input logic         MOIST_DONE_I,
    // Flags and code.
    input logic [W-1:0] CHARGER_EVENT_FLAGS_O,
    input logic [W-1:0] LINK_EVENT_FLAGS_O,
    input logic [W-1:0] TRANSFER_MOISTURE_EVENT_FLAGS_O,
    input logic [W-1:0] CMD_STATUS_O
);
    wire [W-1:0] clr_chg = (REG_WR_I && REG_ADDR_I == `EVF_ADDR_CHG) ? REG_WDATA_I : {W{1'b0}};

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Level changes must be held two samples before the sync chain sees them.
    sequence s_temp_edge;
        $changed(TEMP_REGULATION_STATE_I) ##1 $stable(TEMP_REGULATION_STATE_I);
    endsequence
    sequence s_short_rise;
        !SHORT_TRANSFER_STATE_I [*3] ##1 SHORT_TRANSFER_STATE_I [*2];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    AST_TEMP_CHANGE:
        assert property (s_temp_edge |-> ##3 CHARGER_EVENT_FLAGS_O[7])
        else $error("temperature change not flagged");
    AST_SHORT_RISE:
        assert property (s_short_rise |-> ##3 LINK_EVENT_FLAGS_O[4])
        else $error("short transfer rise not flagged");
    AST_SHORT_RISE_ONLY:
        assert property (s_short_rise ##0 !LINK_EVENT_FLAGS_O[3] |-> !LINK_EVENT_FLAGS_O[3] [*4])
        else $error("short transfer rise set the fall flag");
    AST_CMD_DONE:
        assert property (CMD_DONE_I |=> LINK_EVENT_FLAGS_O[1])
        else $error("command done not flagged");
    AST_CMD_ERROR:
        assert property (CMD_ERROR_I |=> LINK_EVENT_FLAGS_O[0])
        else $error("command error not flagged");
    AST_MOIST_DONE:
        assert property (MOIST_DONE_I |=> TRANSFER_MOISTURE_EVENT_FLAGS_O[5])
        else $error("moisture done not flagged");
    AST_CODE_VALID:
        assert property (1'b1 |=> CMD_STATUS_O == (($past(CMD_DONE_I) || $past(CMD_ERROR_I)) ?
                         $past(CMD_STATUS_CODE_I) : $past(CMD_STATUS_O)))
        else $error("command code not captured with done or error");
    AST_CHG_STICKY:
        assert property (1'b1 |=> ($past(CHARGER_EVENT_FLAGS_O) & ~$past(clr_chg)
                         & ~CHARGER_EVENT_FLAGS_O) == {W{1'b0}})
        else $error("charger flag dropped without a clear");
    AST_LINK_CLEAR:
        assert property (REG_WR_I && REG_ADDR_I == `EVF_ADDR_LINK && REG_WDATA_I[1] && !CMD_DONE_I
                         |=> !LINK_EVENT_FLAGS_O[1])
        else $error("done flag not cleared by write");
endmodule // evf_event_flags_props

bind evf_event_flags evf_event_flags_props #(.W(W)) u_props (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
    .REG_WDATA_I(REG_WDATA_I), .TEMP_REGULATION_STATE_I(TEMP_REGULATION_STATE_I),
    .SHORT_TRANSFER_STATE_I(SHORT_TRANSFER_STATE_I), .CMD_DONE_I(CMD_DONE_I),
    .CMD_ERROR_I(CMD_ERROR_I), .CMD_STATUS_CODE_I(CMD_STATUS_CODE_I), .MOIST_DONE_I(MOIST_DONE_I),
    .CHARGER_EVENT_FLAGS_O(CHARGER_EVENT_FLAGS_O), .LINK_EVENT_FLAGS_O(LINK_EVENT_FLAGS_O),
    .TRANSFER_MOISTURE_EVENT_FLAGS_O(TRANSFER_MOISTURE_EVENT_FLAGS_O), .CMD_STATUS_O(CMD_STATUS_O)
);

/* File: verif/evf_event_flags_tb.sv */
// Self-checking bench for the event flag block: each read notes its expected
// byte in a queue, and a monitor compares it when the read answer pulses.
// Assumes the register port answers one cycle after the read strobe.
`include "evf_defines.vh"

module evf_event_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk    = 1'b0;
    logic       rst_n  = 1'b0;
    logic [7:0] addr   = 8'h00;
    logic       wr     = 1'b0;
    logic       rd     = 1'b0;
    logic [7:0] wdata  = 8'h00;
    logic [7:0] code   = 8'h00;
    logic [7:0] chg_lv = 8'h00;
    logic [3:0] lnk_lv = 4'h0;
    logic [2:0] xfm_lv = 3'h0;
    logic [7:0] lnk_p  = 8'h00;
    logic [7:0] xfm_p  = 8'h00;
    wire  [7:0] rdata;
    wire        rvalid;
    logic [7:0] exp_q[$];
    logic [31:0] m;
    logic [7:0] cd, cs, e_l, e_x;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         seed = 32'h2f1329b8;

    evf_event_flags dut (
        .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RDATA_VALID_O(rvalid),
        .TEMP_REGULATION_STATE_I(chg_lv[7]), .CHARGER_REVERSE_STATE_I(chg_lv[6]),
        .BATT_VOLTAGE_REGULATION_STATE_I(chg_lv[5]), .STEP_CHARGE_STATE_I(chg_lv[4]),
        .CHARGER_DROPOUT_STATE_I(chg_lv[3]), .SYS_REGULATOR_DROPOUT_STATE_I(chg_lv[2]),
        .LINE_VOLTAGE_GOOD_I(chg_lv[1]), .SYS_REVERSE_STATE_I(chg_lv[0]),
        .LINK_CONNECTED_STATE_I(lnk_lv[3]), .LINK_WAITING_STATE_I(lnk_lv[2]),
        .LINK_IDLE_STATE_I(lnk_lv[1]), .SHORT_TRANSFER_STATE_I(lnk_lv[0]),
        .LONG_TRANSFER_STATE_I(xfm_lv[2]), .BATT_ABOVE_UNDERVOLTAGE_I(xfm_lv[1]),
        .LINE_MOISTURE_STATE_I(xfm_lv[0]), .NEW_DATA_STORED_I(lnk_p[2]), .CMD_DONE_I(lnk_p[1]),
        .CMD_ERROR_I(lnk_p[0]), .CMD_STATUS_CODE_I(code), .MOIST_DONE_I(xfm_p[5]),
        .MOIST_VALID_I(xfm_p[3]), .RES_ABORT_I(xfm_p[2]), .RES_OPEN_I(xfm_p[1]),
        .RES_GROUND_I(xfm_p[0]), .CHARGER_EVENT_FLAGS_O(), .LINK_EVENT_FLAGS_O(),
        .TRANSFER_MOISTURE_EVENT_FLAGS_O(), .CMD_STATUS_O()
    );

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    // One access; for a read, d is the byte expected back.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rd3(input logic [7:0] c, input logic [7:0] l, input logic [7:0] x);
        acc(1'b0, `EVF_ADDR_CHG, c);
        acc(1'b0, `EVF_ADDR_LINK, l);
        acc(1'b0, `EVF_ADDR_XFER, x);
    endtask

    // Levels are held well past the two-sample minimum before anything else moves.
    task automatic stim(input logic [31:0] v, input logic [7:0] c8);
        @(posedge clk);
        chg_lv <= chg_lv ^ v[7:0];
        lnk_lv <= lnk_lv ^ v[11:8];
        xfm_lv <= xfm_lv ^ v[14:12];
        lnk_p <= v[23:16] & `EVF_LNK_PULSE_MASK;
        xfm_p <= v[31:24] & `EVF_XFM_PULSE_MASK;
        code <= c8;
        @(posedge clk);
        lnk_p <= 8'h00;
        xfm_p <= 8'h00;
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("mismatch at %0t: unexpected read answer", $time);
            end else begin
                check(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        cs = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd3(8'h00, 8'h00, 8'h00);
        acc(1'b0, `EVF_ADDR_CMD_STATUS, 8'h00);
        acc(1'b0, 8'h3C, `EVF_READ_UNMAPPED);
        for (int k = 0; k < 8; k++) begin
            m = (k > 5) ? 32'hFFFFFFFF : $random(seed);
            cd = 8'($random(seed));
            e_l = {m[11:9], m[8] & ~lnk_lv[0], m[8] & lnk_lv[0], m[18:16]};
            e_x = {m[14:13], m[29], m[12], m[27:24]};
            if (m[17:16] != 2'b00) cs = cd;
            acc(1'b1, `EVF_ADDR_CHG, 8'hFF);
            acc(1'b1, `EVF_ADDR_LINK, 8'hFF);
            acc(1'b1, `EVF_ADDR_XFER, 8'hFF);
            stim(m, cd);
            acc(1'b0, `EVF_ADDR_CHG, m[7:0]);
            acc(1'b0, `EVF_ADDR_LINK, e_l);
            acc(1'b0, `EVF_ADDR_XFER, e_x);
            acc(1'b0, `EVF_ADDR_CMD_STATUS, cs);
        end
        // Partial clear, then writes to read-only and unmapped places change nothing.
        acc(1'b1, `EVF_ADDR_CHG, 8'h0F);
        acc(1'b1, `EVF_ADDR_CMD_STATUS, 8'hFF);
        acc(1'b1, 8'h3C, 8'hFF);
        rd3(8'hF0, e_l, e_x);
        acc(1'b0, `EVF_ADDR_CMD_STATUS, cs);
        // Read, clear and a new done event all in one cycle.
        @(posedge clk);
        lnk_p <= 8'h02;
        wr <= 1'b1;
        rd <= 1'b1;
        addr <= `EVF_ADDR_LINK;
        wdata <= 8'hFF;
        exp_q.push_back(e_l);
        @(posedge clk);
        lnk_p <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        acc(1'b0, `EVF_ADDR_LINK, 8'h02);
        // A second reset in mid-run zeroes everything, then detection works again.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd3(8'h00, 8'h00, 8'h00);
        acc(1'b0, `EVF_ADDR_CMD_STATUS, 8'h00);
        stim(32'h000000A5, 8'h00);
        rd3(8'hA5, 8'h00, 8'h00);
        repeat (4) @(posedge clk);
        // Every read must have been answered by now.
        check(8'(exp_q.size()), 8'h00);
        test_done();
    end
endmodule // evf_event_flags_tb
